// *** inc/interval_timer_pkg.sv ***
package interval_timer_pkg;

  localparam int unsigned WORD_W        = 32;
  localparam int unsigned ADDR_W        = 24;
  localparam int unsigned STAT_W        = 64;
  localparam int unsigned CR_W          = 32;
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned TICK_US       = 3330;
  localparam int unsigned TICK_CYCLES   = TICK_US * CLK_MHZ;
  localparam int unsigned EXT_MASK_BIT  = 7;
  localparam int unsigned CR0_TIMER_BIT = 24;
  localparam int unsigned DEC_BIT       = 23;
  localparam int unsigned EXT_MASK_IDX  = STAT_W - 1 - EXT_MASK_BIT;
  localparam int unsigned CR0_TIMER_IDX = CR_W - 1 - CR0_TIMER_BIT;
  localparam int unsigned DEC_IDX       = WORD_W - 1 - DEC_BIT;
  localparam logic [WORD_W-1:0] DEC_STEP  = 32'h0000_0001 << DEC_IDX;
  localparam logic [ADDR_W-1:0] WORD_ADDR = 24'h000050;
  localparam logic [WORD_W-1:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } timer_state_t;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic              ack;
    logic [WORD_W-1:0] rdata;
  } mem_rsp_t;

endpackage

// *** core/interval_timer.sv ***
// Operation
// [RQ1] Every 3.33 ms subtract one at bit 23 from the stored interval word.
// [RQ2] Raise an external interruption request when a decrement goes from zero to negative.
// [RQ3] Present the request only while program status word bit 7 and CR0 bit 24 are one.
// [RQ4] Stop decrementing while the time-of-day clock is stopped or in error.
// [RQ5] Word width and tick weight give a countdown range of about 15.5 hours.
// [RQ6] The word is 32-bit two's complement, updated by atomic read-modify-write.
`timescale 1ns/100ps
`default_nettype none
module interval_timer #(
  parameter int unsigned TICK_CYCLES_P = interval_timer_pkg::TICK_CYCLES
) (
  input  wire logic                                   clk_i,
  input  wire logic                                   sys_rst_i,
  input  wire logic                                   time_of_day_clock_stopped_i,
  input  wire logic                                   time_of_day_clock_error_i,
  input  wire logic [interval_timer_pkg::STAT_W-1:0]  program_status_word_i,
  input  wire logic [interval_timer_pkg::CR_W-1:0]    cr0_i,
  input  wire logic                                   ext_ack_i,
  input  wire interval_timer_pkg::mem_rsp_t           mem_rsp_i,
  output var  interval_timer_pkg::mem_req_t           mem_req_o,
  output var  logic                                   ext_irq_o,
  output var  logic                                   pending_o
);
  import interval_timer_pkg::*;

  localparam int unsigned CNT_W = $clog2(TICK_CYCLES_P + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TICK_CYCLES_P - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  timer_state_t      state;
  timer_state_t      next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic              tick_due;
  logic              next_tick_due;
  logic              pending;
  logic              next_pending;
  logic              irq;
  logic              next_irq;
  mem_req_t          mreq;
  mem_req_t          next_mreq;
  logic              halted;
  logic              wrap;
  logic              underflow;
  logic [WORD_W-1:0] dec_word;

  // The interval keeps no time while the time-of-day clock cannot run.
  assign halted    = time_of_day_clock_stopped_i | time_of_day_clock_error_i; // [RQ4]
  assign wrap      = !halted && (cnt == CNT_LAST); // [RQ1]
  // A 32-bit word stepped at 2^8 spans 2^24 ticks, about 15.5 hours.
  assign dec_word  = mem_rsp_i.rdata - DEC_STEP; // [RQ1] [RQ5] [RQ6]
  assign underflow = !mem_rsp_i.rdata[WORD_W-1] && dec_word[WORD_W-1]; // [RQ2]

  always_comb begin
    next_cnt      = cnt;
    next_tick_due = tick_due;
    next_state    = state;
    next_mreq     = mreq;
    next_pending  = pending;
    if (!halted) begin // [RQ4]
      next_cnt = wrap ? CNT_ZERO : cnt + 1'b1;
    end
    if (wrap) begin
      next_tick_due = 1'b1;
    end
    case (state)
      ST_IDLE: begin
        // Ticks are not queued: one overrun tick is merged, never doubled.
        if ((tick_due || wrap) && !halted) begin // [RQ1] [RQ4]
          next_state     = ST_READ;
          next_tick_due  = 1'b0;
          next_mreq.req  = 1'b1;
          next_mreq.we   = 1'b0;
          next_mreq.addr = WORD_ADDR;
        end
      end
      ST_READ: begin
        // A halt mid-transfer lets the write finish, so the stored word is never torn.
        if (mem_rsp_i.ack) begin // [RQ6]
          next_state      = ST_WRITE;
          next_mreq.we    = 1'b1;
          next_mreq.wdata = dec_word; // [RQ1]
          if (underflow) begin
            next_pending = 1'b1; // [RQ2]
          end
        end
      end
      ST_WRITE: begin
        if (mem_rsp_i.ack) begin
          next_state    = ST_IDLE;
          next_mreq.req = 1'b0;
          next_mreq.we  = 1'b0;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_mreq  = '0;
      end
    endcase
    // A fresh underflow in the acknowledge cycle keeps the request pending.
    if (ext_ack_i && !(state == ST_READ && mem_rsp_i.ack && underflow)) begin
      next_pending = 1'b0;
    end
    // Gating the next value keeps the request pin a pure flip-flop output.
    next_irq = next_pending && program_status_word_i[EXT_MASK_IDX]
               && cr0_i[CR0_TIMER_IDX]; // [RQ3]
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state    <= ST_IDLE;
      cnt      <= CNT_ZERO;
      tick_due <= 1'b0;
      pending  <= 1'b0;
      irq      <= 1'b0;
      mreq     <= '0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      tick_due <= next_tick_due;
      pending  <= next_pending;
      irq      <= next_irq;
      mreq     <= next_mreq;
    end
  end

  assign mem_req_o = mreq;
  assign ext_irq_o = irq;
  assign pending_o = pending;

  // Each check reads registered state, so most of them look one edge after the cause.
  sequence s_tick_in_idle;
    state == ST_IDLE && wrap;
  endsequence

  sequence s_read_issued;
    state == ST_READ && mem_req_o.req && !mem_req_o.we && mem_req_o.addr == WORD_ADDR;
  endsequence

  sequence s_read_ack;
    state == ST_READ && mem_rsp_i.ack;
  endsequence

  sequence s_read_ack_underflow;
    state == ST_READ && mem_rsp_i.ack && underflow;
  endsequence

  sequence s_write_of_decrement;
    mem_req_o.req && mem_req_o.we && mem_req_o.wdata == $past(dec_word);
  endsequence

  sequence s_write_ack;
    state == ST_WRITE && mem_rsp_i.ack;
  endsequence

  sequence s_released;
    state == ST_IDLE && !mem_req_o.req && !mem_req_o.we;
  endsequence

  chk_tick_starts_read: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ1]
    s_tick_in_idle |=> s_read_issued)
    else $error("Tick did not start a read.");

  chk_write_value: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ1] [RQ6]
    s_read_ack |=> s_write_of_decrement)
    else $error("Written word is not the read word minus one step.");

  chk_step_weight: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ5]
    s_read_ack |=> (mem_req_o.wdata[DEC_IDX-1:0] == $past(mem_rsp_i.rdata[DEC_IDX-1:0])
    && mem_req_o.wdata[WORD_W-1:DEC_IDX] == $past(mem_rsp_i.rdata[WORD_W-1:DEC_IDX]) - 1'b1))
    else $error("Decrement does not weigh one at bit 23.");

  chk_underflow_pend: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ2]
    s_read_ack_underflow |=> pending_o)
    else $error("Underflow did not set the pending request.");

  chk_zero_to_negative: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ2]
    s_read_ack_underflow |-> (mem_rsp_i.rdata[WORD_W-1:DEC_IDX] == '0))
    else $error("Request raised for a word above zero.");

  chk_no_false_pend: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ2]
    (!pending_o && !(state == ST_READ && mem_rsp_i.ack && underflow)) |=> !pending_o)
    else $error("Pending request set without an underflow.");

  chk_pend_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ2]
    (pending_o && !ext_ack_i) |=> pending_o)
    else $error("Pending request dropped without an acknowledge.");

  chk_ack_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ3]
    (ext_ack_i && !(state == ST_READ && mem_rsp_i.ack && underflow))
    |=> (!pending_o && !ext_irq_o))
    else $error("Acknowledge did not clear the request.");

  chk_irq_masked: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ3]
    ext_irq_o |-> $past(program_status_word_i[EXT_MASK_IDX] && cr0_i[CR0_TIMER_IDX]))
    else $error("Interruption presented while masked.");

  chk_irq_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ3]
    (pending_o && !ext_ack_i && program_status_word_i[EXT_MASK_IDX]
     && cr0_i[CR0_TIMER_IDX]) |=> ext_irq_o)
    else $error("Enabled pending request not presented.");

  chk_irq_needs_pend: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ3]
    ext_irq_o |-> pending_o)
    else $error("Interruption presented with nothing pending.");

  chk_halt_freeze: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ4]
    (state == ST_IDLE && halted) |=> (state == ST_IDLE && $stable(cnt)))
    else $error("Timer advanced while the clock was halted.");

  chk_halt_no_start: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ4]
    (state == ST_IDLE && halted) |=> !mem_req_o.req)
    else $error("Storage access started while the clock was halted.");

  chk_rmw_atomic: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ6]
    (state == ST_WRITE) |-> (mem_req_o.req && mem_req_o.we && mem_req_o.addr == WORD_ADDR))
    else $error("Read-modify-write broken up.");

  chk_req_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ6]
    (mem_req_o.req && !mem_rsp_i.ack) |=> (mem_req_o.req && $stable(mem_req_o.we)
    && $stable(mem_req_o.addr) && $stable(mem_req_o.wdata)))
    else $error("Storage request changed before its acknowledge.");

  chk_write_release: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ6]
    s_write_ack |=> s_released)
    else $error("Request not released after the write.");

endmodule
`default_nettype wire

// *** tb/test_interval_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_interval_timer;
  import interval_timer_pkg::*;
  logic              clk_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic              time_of_day_clock_stopped_i = 1'b0;
  logic              time_of_day_clock_error_i = 1'b0;
  logic [STAT_W-1:0] program_status_word_i = 64'h0100_0000_0000_0000;
  logic [CR_W-1:0]   cr0_i = 32'h0000_0080;
  logic              ext_ack_i = 1'b0;
  mem_rsp_t          mem_rsp_i = '0;
  mem_req_t          mem_req_o;
  logic              ext_irq_o;
  logic              pending_o;
  logic [WORD_W-1:0] word = 32'h0000_0300;
  logic              hold = 1'b0;
  logic              mem_busy = 1'b0;
  int                writes = 0;
  int                errors = 0;
  int                samples_checked = 0;
  interval_timer #(.TICK_CYCLES_P(64)) interval_timer_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .time_of_day_clock_stopped_i(time_of_day_clock_stopped_i),
    .time_of_day_clock_error_i(time_of_day_clock_error_i), .cr0_i(cr0_i),
    .program_status_word_i(program_status_word_i), .ext_ack_i(ext_ack_i),
    .mem_rsp_i(mem_rsp_i), .mem_req_o(mem_req_o), .ext_irq_o(ext_irq_o), .pending_o(pending_o));
  initial forever #4 clk_i = ~clk_i;
  // Storage answers a cycle late, and shows inverted data outside an answer.
  always @(negedge clk_i) begin
    mem_rsp_i.ack <= 1'b0;
    mem_rsp_i.rdata <= ~word;
    hold <= mem_req_o.req & ~hold & ~mem_rsp_i.ack & ~mem_busy;
    if (hold && !mem_rsp_i.ack) begin
      mem_rsp_i.ack <= 1'b1;
      mem_rsp_i.rdata <= word;
      if (mem_req_o.addr !== WORD_ADDR) check(32'h0, 32'h1);
      if (mem_req_o.we) begin
        word <= mem_req_o.wdata;
        writes <= writes + 1;
      end
    end
  end
  task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ticks are 64 cycles apart, so the checks after a write see a quiet word.
  task automatic wait_write();
    int goal;
    int k;
    goal = writes + 1;
    k = 0;
    while (writes < goal && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 400) check(32'h0, 32'h1);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic pulse_ack();
    ext_ack_i = 1'b1;
    @(negedge clk_i);
    ext_ack_i = 1'b0;
    @(negedge clk_i);
    check({30'h0, pending_o, ext_irq_o}, 32'h0);
  endtask
  task automatic decrement_scenario();
    wait_write();
    check(word, 32'h0000_0200);
    check({31'h0, pending_o}, 32'h0);
    word = 32'h0000_0080;
  endtask
  task automatic underflow_scenario();
    wait_write();
    check(word, 32'hFFFF_FF80);
    check({30'h0, pending_o, ext_irq_o}, 32'h3);
    pulse_ack();
    wait_write();
    check(word, 32'hFFFF_FE80);
    check({31'h0, pending_o}, 32'h0);
    word = 32'h0000_0010;
    cr0_i = 32'h0;
  endtask
  task automatic mask_scenario();
    wait_write();
    check({30'h0, pending_o, ext_irq_o}, 32'h2);
    program_status_word_i = '0;
    cr0_i = 32'h0000_0080;
    repeat (3) @(negedge clk_i);
    check({31'h0, ext_irq_o}, 32'h0);
    program_status_word_i = 64'h0100_0000_0000_0000;
    repeat (2) @(negedge clk_i);
    check({31'h0, ext_irq_o}, 32'h1);
    pulse_ack();
    word = 32'h0000_0500;
  endtask
  task automatic halt_scenario(input logic err);
    wait_write();
    time_of_day_clock_stopped_i = ~err;
    time_of_day_clock_error_i = err;
    repeat (200) @(negedge clk_i);
    check(word, 32'h0000_0400);
    time_of_day_clock_stopped_i = 1'b0;
    time_of_day_clock_error_i = 1'b0;
    wait_write();
    check(word, 32'h0000_0300);
    word = 32'h0000_0500;
  endtask
  // Storage stalls across two more ticks; they must fold into one extra decrement.
  task automatic merge_scenario();
    int base;
    wait_write();
    base = writes;
    mem_busy <= 1'b1;
    repeat (200) @(negedge clk_i);
    mem_busy <= 1'b0;
    repeat (30) @(negedge clk_i);
    check(writes - base, 32'h0000_0002);
    check(word, 32'h0000_0200);
  endtask
  task automatic close_out();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'b0;
    decrement_scenario();
    underflow_scenario();
    mask_scenario();
    halt_scenario(1'b0);
    halt_scenario(1'b1);
    merge_scenario();
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
